// ---- inc/port_access_pkg.sv ----
package port_access_pkg;

  // Port geometry
  localparam int PORT_W = 4;
  localparam int NUM_PORTS = 4;
  localparam int PAIR_LO = 2;
  localparam int PAIR_HI = 3;
  localparam logic [3:0] PORT_BANK = 4'hf;

  // Register byte offsets
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_BANK = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_PINS = 8'h10;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PORT_LSB = 5;
  localparam int CMD_BIT_LSB = 7;
  localparam int CMD_USE_L = 9;
  localparam int CMD_L_LSB = 12;
  localparam int CMD_ACC_LSB = 16;
  localparam int CMD_CARRY = 24;

  // Low index register split
  localparam int L_PORT_LSB = 2;
  localparam int L_BIT_LSB = 0;

  // Bank register and result fields
  localparam int BANK_SEL_LSB = 0;
  localparam int BANK_FLAG_BIT = 4;
  localparam int RES_SKIP = 8;
  localparam int RES_CARRY = 9;
  localparam int RES_REFUSED = 10;

  // Reset values
  localparam logic [3:0] LATCH_RESET = 4'h0;
  localparam logic MODE_RESET = 1'b0;

  typedef enum logic [4:0] {
    OP_READ4 = 5'h00, OP_READ8 = 5'h01, OP_WRITE4 = 5'h02, OP_WRITE8 = 5'h03,
    OP_XCH4 = 5'h04, OP_XCH8 = 5'h05, OP_INCREMENT_SKIP_OP = 5'h06, OP_CMP4 = 5'h07,
    OP_CMP8 = 5'h08, OP_SKT = 5'h09, OP_SKF = 5'h0a, OP_BIT_LOAD = 5'h0b,
    OP_BIT_AND = 5'h0c, OP_BIT_OR = 5'h0d, OP_BIT_XOR = 5'h0e, OP_BIT_SET = 5'h0f,
    OP_BIT_CLR = 5'h10, OP_BIT_MOV = 5'h11, OP_TEST_CLR = 5'h12
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } state_t;

endpackage : port_access_pkg

// ---- inc/latch_if.sv ----
`timescale 1ns/1ps
interface latch_if #(
  parameter int N = 4,
  parameter int W = 4
);
  logic [N-1:0] wr_en;
  logic [N*W-1:0] wr_data;
  logic [N*W-1:0] latch;

  modport ctrl (output wr_en, output wr_data, input latch);
  modport store (input wr_en, input wr_data, output latch);
endinterface : latch_if

// ---- verilog/port_latch_bank.sv ----
`timescale 1ns/1ps
module port_latch_bank #(
  parameter int N = 4,
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic reset,
  latch_if.store lif
);

  typedef struct packed {
    logic [N*W-1:0] latch;
  } bank_state_t;

  bank_state_t s_q;
  bank_state_t s_d;
  logic [N*W-1:0] nxt_latch;

  // One nibble of output latch per port
  for (genvar p = 0; p < N; p++) begin : g_port
    assign nxt_latch[p*W +: W] = lif.wr_en[p] ? lif.wr_data[p*W +: W] : s_q.latch[p*W +: W];
  end

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.latch = nxt_latch;
  end

  // Latches clear on reset
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= {N{port_access_pkg::LATCH_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  assign lif.latch = s_q.latch;

endmodule : port_latch_bank

// ---- verilog/digital_port_access.sv ----
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module digital_port_access #(
  parameter int NUM_PORTS = port_access_pkg::NUM_PORTS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_PORTS*port_access_pkg::PORT_W-1:0] pin_in,
  output logic [NUM_PORTS*port_access_pkg::PORT_W-1:0] pin_out,
  output logic [NUM_PORTS*port_access_pkg::PORT_W-1:0] pin_oe
);

  localparam int W = port_access_pkg::PORT_W;
  localparam int NW = NUM_PORTS * W;

  typedef struct packed {
    port_access_pkg::state_t state;
    logic [NUM_PORTS-1:0] mode;
    logic bank_flag;
    logic [3:0] bank_sel;
    port_access_pkg::op_t op;
    logic [1:0] port;
    logic [1:0] bitp;
    logic [7:0] acc;
    logic carry;
    logic [7:0] res;
    logic skip;
    logic refused;
    logic [31:0] rdata;
  } ctl_state_t;

  ctl_state_t s_q;
  ctl_state_t s_d;

  latch_if #(.N(NUM_PORTS), .W(W)) lif ();

  logic [NW-1:0] src_all;
  logic access;
  logic [3:0] nibble;
  logic [7:0] pair;
  logic one_bit;
  logic [3:0] rmw;
  logic [3:0] inc;
  logic [1:0] cap_port;
  logic [1:0] cap_bit;
  logic bank_ok;

  // Output latches live in their own bank
  port_latch_bank #(.N(NUM_PORTS), .W(W)) u_bank (
    .clk(clk),
    .reset(reset),
    .lif(lif)
  );

  // Per-port read source and pin drive
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    // Pins in input mode, latch in output mode
    assign src_all[p*W +: W] = s_q.mode[p] ? lif.latch[p*W +: W] : pin_in[p*W +: W];
    // Buffer follows the mode bit
    assign pin_oe[p*W +: W] = {W{s_q.mode[p]}};
  end

  // Latch contents always sit on the pins; the enable decides whether they show
  assign pin_out = lif.latch;

  assign access = psel & penable;

  // Direct or low-index addressing
  always_comb begin
    if (pwdata[port_access_pkg::CMD_USE_L]) begin
      cap_port = pwdata[port_access_pkg::CMD_L_LSB + port_access_pkg::L_PORT_LSB +: 2];
      cap_bit = pwdata[port_access_pkg::CMD_L_LSB + port_access_pkg::L_BIT_LSB +: 2];
    end else begin
      cap_port = pwdata[port_access_pkg::CMD_PORT_LSB +: 2];
      cap_bit = pwdata[port_access_pkg::CMD_BIT_LSB +: 2];
    end
  end

  // Port space reachable only with flag clear or bank 15
  assign bank_ok = !s_q.bank_flag || (s_q.bank_sel == port_access_pkg::PORT_BANK);

  // Operand views of the addressed port and of the fixed port pair
  always_comb begin
    nibble = src_all[int'(s_q.port)*W +: W];
    pair = {src_all[port_access_pkg::PAIR_HI*W +: W], src_all[port_access_pkg::PAIR_LO*W +: W]};
    one_bit = nibble[s_q.bitp];
    inc = nibble + 4'h1;
  end

  // Bus decode, command execution and result
  always_comb begin
    s_d = s_q;
    pready = 1'b1;
    pslverr = 1'b0;
    lif.wr_en = '0;
    lif.wr_data = lif.latch;
    rmw = nibble; // Unaddressed bits from the mode-dependent source
    case (s_q.state)
      port_access_pkg::ST_IDLE: begin
        // Read data captured in the setup phase so it comes from a flop
        if (psel && !penable) begin
          case (paddr)
            port_access_pkg::REG_MODE: begin
              s_d.rdata = 32'(s_q.mode);
            end
            port_access_pkg::REG_BANK: begin
              s_d.rdata = 32'({s_q.bank_flag, s_q.bank_sel});
            end
            port_access_pkg::REG_RESULT: begin
              s_d.rdata = 32'({s_q.refused, s_q.carry, s_q.skip, s_q.res});
            end
            port_access_pkg::REG_PINS: begin
              s_d.rdata = 32'(pin_in);
            end
            default: begin
              s_d.rdata = 32'h0000_0000;
            end
          endcase
        end
        if (access) begin
          case (paddr)
            port_access_pkg::REG_MODE: begin
              if (pwrite) begin
                s_d.mode = pwdata[NUM_PORTS-1:0];
              end
            end
            port_access_pkg::REG_BANK: begin
              if (pwrite) begin
                s_d.bank_sel = pwdata[port_access_pkg::BANK_SEL_LSB +: 4];
                s_d.bank_flag = pwdata[port_access_pkg::BANK_FLAG_BIT];
              end
            end
            port_access_pkg::REG_CMD: begin
              // Command writes hold the bus until executed
              if (pwrite) begin
                s_d.op = port_access_pkg::op_t'(pwdata[port_access_pkg::CMD_OP_LSB +: 5]);
                s_d.port = cap_port;
                s_d.bitp = cap_bit;
                s_d.acc = pwdata[port_access_pkg::CMD_ACC_LSB +: 8];
                s_d.carry = pwdata[port_access_pkg::CMD_CARRY];
                s_d.state = port_access_pkg::ST_EXEC;
                pready = 1'b0;
              end
            end
            port_access_pkg::REG_RESULT, port_access_pkg::REG_PINS: begin
              // Read-only; writes are dropped quietly
            end
            default: begin
              pslverr = 1'b1;
            end
          endcase
        end
      end
      port_access_pkg::ST_EXEC: begin
        pready = 1'b0;
        s_d.state = port_access_pkg::ST_DONE;
        s_d.skip = 1'b0;
        s_d.res = 8'h00;
        s_d.refused = !bank_ok;
        if (bank_ok) begin
          case (s_q.op)
            port_access_pkg::OP_READ4: begin
              s_d.res = {4'h0, nibble};
            end
            port_access_pkg::OP_READ8: begin
              s_d.res = pair;
            end
            port_access_pkg::OP_WRITE4: begin
              // Latch loads either way; pins show it only in output mode
              lif.wr_en[s_q.port] = 1'b1;
              lif.wr_data[int'(s_q.port)*W +: W] = s_q.acc[3:0];
            end
            port_access_pkg::OP_WRITE8: begin
              // Byte write to the pair
              lif.wr_en[port_access_pkg::PAIR_LO] = 1'b1;
              lif.wr_en[port_access_pkg::PAIR_HI] = 1'b1;
              lif.wr_data[port_access_pkg::PAIR_LO*W +: W] = s_q.acc[3:0];
              lif.wr_data[port_access_pkg::PAIR_HI*W +: W] = s_q.acc[7:4];
            end
            port_access_pkg::OP_XCH4: begin
              // Old source out, accumulator in
              s_d.res = {4'h0, nibble};
              lif.wr_en[s_q.port] = 1'b1;
              lif.wr_data[int'(s_q.port)*W +: W] = s_q.acc[3:0];
            end
            port_access_pkg::OP_XCH8: begin
              // Byte exchange on the pair
              s_d.res = pair;
              lif.wr_en[port_access_pkg::PAIR_LO] = 1'b1;
              lif.wr_en[port_access_pkg::PAIR_HI] = 1'b1;
              lif.wr_data[port_access_pkg::PAIR_LO*W +: W] = s_q.acc[3:0];
              lif.wr_data[port_access_pkg::PAIR_HI*W +: W] = s_q.acc[7:4];
            end
            port_access_pkg::OP_INCREMENT_SKIP_OP: begin
              // Source plus one into latch, skip on wrap
              s_d.res = {4'h0, inc};
              s_d.skip = (inc == 4'h0);
              lif.wr_en[s_q.port] = 1'b1;
              lif.wr_data[int'(s_q.port)*W +: W] = inc;
            end
            port_access_pkg::OP_CMP4: begin
              s_d.skip = (nibble == s_q.acc[3:0]);
            end
            port_access_pkg::OP_CMP8: begin
              s_d.skip = (pair == s_q.acc);
            end
            port_access_pkg::OP_SKT: begin
              s_d.skip = one_bit;
            end
            port_access_pkg::OP_SKF: begin
              s_d.skip = !one_bit;
            end
            port_access_pkg::OP_BIT_LOAD: begin
              s_d.carry = one_bit;
            end
            port_access_pkg::OP_BIT_AND: begin
              s_d.carry = s_q.carry & one_bit;
            end
            port_access_pkg::OP_BIT_OR: begin
              s_d.carry = s_q.carry | one_bit;
            end
            port_access_pkg::OP_BIT_XOR: begin
              s_d.carry = s_q.carry ^ one_bit;
            end
            port_access_pkg::OP_BIT_SET: begin
              // Read-modify-write of the nibble
              rmw[s_q.bitp] = 1'b1;
              lif.wr_en[s_q.port] = 1'b1;
              lif.wr_data[int'(s_q.port)*W +: W] = rmw;
            end
            port_access_pkg::OP_BIT_CLR: begin
              rmw[s_q.bitp] = 1'b0;
              lif.wr_en[s_q.port] = 1'b1;
              lif.wr_data[int'(s_q.port)*W +: W] = rmw;
            end
            port_access_pkg::OP_BIT_MOV: begin
              rmw[s_q.bitp] = s_q.carry;
              lif.wr_en[s_q.port] = 1'b1;
              lif.wr_data[int'(s_q.port)*W +: W] = rmw;
            end
            port_access_pkg::OP_TEST_CLR: begin
              // Test first, then clear the same bit
              s_d.skip = one_bit;
              rmw[s_q.bitp] = 1'b0;
              lif.wr_en[s_q.port] = 1'b1;
              lif.wr_data[int'(s_q.port)*W +: W] = rmw;
            end
            default: begin
              // Unknown code: no port effect
            end
          endcase
        end
      end
      port_access_pkg::ST_DONE: begin
        // Command write completes here
        s_d.state = port_access_pkg::ST_IDLE;
      end
      default: begin
        s_d.state = port_access_pkg::ST_IDLE;
      end
    endcase
  end

  // Modes clear on reset so every port starts as input
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.state <= port_access_pkg::ST_IDLE;
      s_q.mode <= {NUM_PORTS{port_access_pkg::MODE_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;

endmodule : digital_port_access

// ---- verif/pad_model.sv ----
`timescale 1ns/1ps
module pad_model #(
  parameter int W = 16
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin_in
);
  // Driven pins read back the latch, released pins show the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : pad_model

// ---- verif/digital_port_access_assertions.sv ----
`timescale 1ns/1ps
module digital_port_access_assertions #(
  parameter int NUM_PORTS = port_access_pkg::NUM_PORTS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_PORTS*port_access_pkg::PORT_W-1:0] pin_in,
  input wire logic [NUM_PORTS*port_access_pkg::PORT_W-1:0] pin_out,
  input wire logic [NUM_PORTS*port_access_pkg::PORT_W-1:0] pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic acc, cmd_acc, mode_wr, unmapped;
  logic [NUM_PORTS*port_access_pkg::PORT_W-1:0] oe_exp;
  // Decoded access phase
  assign acc = psel && penable;
  assign cmd_acc = acc && pwrite && paddr == port_access_pkg::REG_CMD;
  assign mode_wr = acc && pwrite && pready && paddr == port_access_pkg::REG_MODE;
  assign unmapped = paddr > port_access_pkg::REG_PINS || paddr[1:0] != 2'h0;
  // Mode bit spread over its nibble
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      oe_exp[p*4 +: 4] = {4{pwdata[p]}};
    end
  end
  sequence s_cmd_setup;
    psel && !penable && pwrite && paddr == port_access_pkg::REG_CMD;
  endsequence
  sequence s_cmd_wait;
    !pready ##1 !pready ##1 pready;
  endsequence
  property p_cmd_wait;
    s_cmd_setup ##1 acc |-> s_cmd_wait;
  endproperty
  a_cmd_wait: assert property (p_cmd_wait) else $error("cmd wait wrong");
  property p_fast_ready;
    acc && !cmd_acc |-> pready;
  endproperty
  a_fast_ready: assert property (p_fast_ready) else $error("ready late");
  property p_err;
    acc |-> pslverr == unmapped;
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  // Checked during reset too, so no disable here
  property p_reset_clear;
    disable iff (1'b0) reset |=> pin_oe == '0 && pin_out == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset not clear");
  property p_oe_follow;
    mode_wr |=> pin_oe == $past(oe_exp);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("enable wrong");
  property p_oe_hold;
    $changed(pin_oe) |-> $past(mode_wr) || $past(reset);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("enable moved");
  property p_out_hold;
    $changed(pin_out) |-> $past(cmd_acc) || $past(reset);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("latch moved");
  property p_pins_read;
    psel && !penable && !pwrite && paddr == port_access_pkg::REG_PINS
      |=> prdata[15:0] == $past(pin_in[15:0]);
  endproperty
  a_pins_read: assert property (p_pins_read) else $error("pin read wrong");
endmodule : digital_port_access_assertions

bind digital_port_access digital_port_access_assertions #(.NUM_PORTS(NUM_PORTS)) chk_inst (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe));

// ---- verif/digital_port_access_logic_test.sv ----
`timescale 1ns/1ps
module digital_port_access_logic_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, exp_res, mask, r, c;
  logic pready, pslverr, e;
  logic [15:0] pin_in, pin_out, pin_oe;
  logic [3:0][3:0] ext = '0;
  logic [3:0][3:0] latch_m = '0;
  logic [3:0][3:0] oe_e;
  logic [3:0] mode_m = 4'h0;
  logic [4:0] bk;
  int err_count = 0;
  int compares = 0;

  always #5 clk = ~clk;

  digital_port_access #(.NUM_PORTS(4)) digital_port_access_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  pad_model #(.W(16)) pad_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
    .pin_in(pin_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // Holds the request until pready is seen, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Ready, read data and error are all taken at the completing rising edge
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Read source follows the mode bit
  function automatic logic [3:0] src(input logic [1:0] p);
    return mode_m[p] ? latch_m[p] : ext[p];
  endfunction : src

  // Expected result word and latch update of one command
  task automatic predict(input logic [31:0] c, input logic [4:0] bk);
    logic [1:0] p, b;
    logic [3:0] s, n;
    logic [7:0] s8;
    logic v;
    p = c[9] ? c[15:14] : c[6:5];
    b = c[9] ? c[13:12] : c[8:7];
    s = src(p);
    s8 = {src(2'd3), src(2'd2)};
    v = s[b];
    n = s;
    exp_res = 32'h0;
    mask = 32'h400;
    if (bk[4] && bk[3:0] != 4'hf) begin
      exp_res[10] = 1'b1;
      mask = 32'h5ff;
      return;
    end
    case (c[4:0])
      5'h00, 5'h04: begin exp_res[3:0] = s; mask = 32'h40f; end
      5'h01, 5'h05: begin exp_res[7:0] = s8; mask = 32'h4ff; end
      5'h06: begin n = s + 4'h1; exp_res[3:0] = n; exp_res[8] = n == 4'h0; end
      5'h07: exp_res[8] = s == c[19:16];
      5'h08: exp_res[8] = s8 == c[23:16];
      5'h09: exp_res[8] = v;
      // Test-and-clear skips on the old bit, then clears it
      5'h12: begin exp_res[8] = v; n[b] = 1'b0; end
      5'h0a: exp_res[8] = !v;
      5'h0b: exp_res[9] = v;
      5'h0c: exp_res[9] = c[24] & v;
      5'h0d: exp_res[9] = c[24] | v;
      5'h0e: exp_res[9] = c[24] ^ v;
      5'h0f, 5'h11: n[b] = c[4:0] == 5'h0f || c[24];
      default: n[b] = 1'b0;
    endcase
    if (c[4:0] inside {[5'h06:5'h0a], 5'h12}) mask = 32'h500;
    if (c[4:0] inside {[5'h0b:5'h0e]}) mask = 32'h600;
    if (c[4:0] == 5'h06) mask = 32'h50f;
    if (c[4:0] inside {5'h02, 5'h04}) latch_m[p] = c[19:16];
    if (c[4:0] inside {5'h03, 5'h05}) latch_m[3:2] = c[23:16];
    if (c[4:0] inside {[5'h0f:5'h12], 5'h06}) latch_m[p] = n;
  endtask : predict

  // Run needs about 5100 cycles; this allows well over twice that
  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  initial begin
    r = $urandom(32'h0927);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check({pin_oe, pin_out}, 32'h0);
    apb(1'b0, port_access_pkg::REG_MODE, 32'h0, r, e);
    check(r, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    check({e, r[30:0]}, 32'h80000000);
    $display("test reset done");
    for (int i = 0; i < 300; i++) begin
      // First 19 passes walk every op once, one pass wraps all-ones pins
      if (i == 6) begin
        ext <= '1;
        mode_m = 4'h0;
        bk = 5'h0;
        c = 32'h6;
      end else begin
        ext <= 16'($urandom);
        mode_m = 4'($urandom);
        bk = 5'($urandom);
        if (bk[0]) bk[3:0] = 4'hf;
        c = $urandom & 32'h01fff3e0;
        c[4:0] = (i < 19) ? i[4:0] : 5'($urandom_range(18));
      end
      apb(1'b1, port_access_pkg::REG_MODE, {28'h0, mode_m}, r, e);
      apb(1'b1, port_access_pkg::REG_BANK, {27'h0, bk}, r, e);
      apb(1'b1, port_access_pkg::REG_CMD, c, r, e);
      predict(c, bk);
      apb(1'b0, port_access_pkg::REG_RESULT, 32'h0, r, e);
      check(r & mask, exp_res & mask);
      check({16'h0, pin_out}, {16'h0, latch_m});
      for (int p = 0; p < 4; p++) oe_e[p] = {4{mode_m[p]}};
      check({16'h0, pin_oe}, {16'h0, oe_e});
      apb(1'b0, port_access_pkg::REG_PINS, 32'h0, r, e);
      check(r, {16'h0, (oe_e & latch_m) | (~oe_e & ext)});
    end
    $display("test random done");
    complete_run();
  end
endmodule : digital_port_access_logic_test
